/* File: verilog/uart_mode_config.sv */
// Purpose: uart mode registers, error status, baud select and frame engine
// Assumes: byte and single-bit register access from the processor side
// Notes: bit period is sixteen ticks of the selected source
// Operation
// - async bit 7 enables transmit
// - async bit 6 enables receive
// - bits 5:4 choose none/zero/odd/even parity
// - bit 3 selects seven or eight bits
// - bit 2 selects one or two stop
// - receiver checks just one stop bit
// - status bit 2 flags parity mismatch
// - status bit 1 flags missing stop bit
// - status bit 0 flags unread buffer overrun
// - overrun repeats each frame until buffer read
// - status read-only, upper five bits zero
// - baud bits 7:4 choose clock source
// - reset clears all four registers
// - system baud is fx over 2^(n+1)*16
// - external baud is pin rate over 16
// - seven-bit mode drops and zeroes bit 7
`timescale 1ns/1ps
`include "uart_cfg_params.svh"
module uart_mode_config
    import uart_cfg_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        wr_en_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        bit_wr_in,
    input  wire logic [2:0]  bit_idx_in,
    input  wire logic        bit_val_in,
    input  wire logic        rd_en_in,
    output logic [7:0]       rdata_out,
    input  wire logic        rxd_in,
    input  wire logic        ext_baud_clk_pin_in,
    output logic             txd_out,
    output logic             tx_busy_out,
    output logic             tx_done_out,
    output logic             rx_done_out
);
    logic [7:0] async_frame_config;
    logic [7:0] sync_serial_config;
    logic [7:0] baud_source_select;
    logic [7:0] receive_buffer;
    logic       parity_err_flag;
    logic       framing_err_flag;
    logic       overrun_err_flag;
    logic       buf_full;
    logic       tick;
    logic       tx_en;
    logic       rx_en;
    logic [1:0] par_mode;
    logic       char8;
    logic       stop2;
    logic [2:0] last_bit;
    tx_state_t  tx_state;
    logic [7:0] tx_shift;
    logic [3:0] tx_ticks;
    logic [2:0] tx_bits;
    logic       tx_stop_cnt;
    logic       tx_pending;
    logic [7:0] tx_hold;
    logic       tx_par;
    rx_state_t  rx_state;
    logic [7:0] rx_shift;
    logic [3:0] rx_ticks;
    logic [2:0] rx_bits;
    logic       rx_par_bit;
    logic       rx_meta;
    logic       rx_sync;
    logic       rx_complete;
    logic       rx_stop_ok;
    logic       rx_par_bad;
    logic       buf_read;
    logic [7:0] rx_data_out;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        hit = (a == b);
    endfunction
    function automatic logic [7:0] put_bit(input logic [7:0] r, input logic [2:0] i,
                                           input logic v);
        put_bit = (r & ~(8'h01 << i)) | ({7'h00, v} << i);
    endfunction

    assign tx_en    = async_frame_config[`TX_ENABLE_BIT];
    assign rx_en    = async_frame_config[`RX_ENABLE_BIT];
    assign par_mode = async_frame_config[`PARITY_HI_BIT:`PARITY_LO_BIT];
    assign char8    = async_frame_config[`CHAR_LEN_BIT];
    assign stop2    = async_frame_config[`STOP_LEN_BIT];
    assign last_bit = char8 ? 3'h7 : 3'h6;
    assign buf_read = rd_en_in & hit(addr_in, `ADDR_RX_BUFFER);

    baud_tick_gen u_baud (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .src_sel_in (baud_source_select[7:4]),
        .ext_clk_in (ext_baud_clk_pin_in),
        .tick_out   (tick)
    );

    // mode registers: byte or single-bit writes
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            async_frame_config <= `REG_RESET;
            sync_serial_config <= `REG_RESET;
        end else if (wr_en_in || bit_wr_in) begin
            if (hit(addr_in, `ADDR_ASYNC_CFG)) begin
                async_frame_config <= wr_en_in ? wdata_in
                                      : put_bit(async_frame_config, bit_idx_in, bit_val_in);
            end
            if (hit(addr_in, `ADDR_SYNC_CFG)) begin
                sync_serial_config <= wr_en_in ? wdata_in
                                      : put_bit(sync_serial_config, bit_idx_in, bit_val_in);
            end
        end
    end
    // baud select takes whole-byte writes only
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            baud_source_select <= `REG_RESET;
        end else if (wr_en_in && hit(addr_in, `ADDR_BAUD_SEL)) begin
            baud_source_select <= wdata_in;
        end
    end

    // read data, registered one cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_en_in) begin
            unique case (addr_in)
                `ADDR_ASYNC_CFG: rdata_out <= async_frame_config;
                `ADDR_RX_STATUS: rdata_out <= {5'h00, parity_err_flag, framing_err_flag,
                                               overrun_err_flag};
                `ADDR_SYNC_CFG:  rdata_out <= sync_serial_config;
                `ADDR_BAUD_SEL:  rdata_out <= baud_source_select;
                `ADDR_RX_BUFFER: rdata_out <= receive_buffer;
                default:         rdata_out <= 8'h00;
            endcase
        end
    end
    // transmit holding byte, accepted only while enabled and free
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tx_pending <= 1'b0;
            tx_hold    <= 8'h00;
        end else if (wr_en_in && hit(addr_in, `ADDR_TX_DATA) && tx_en && !tx_pending
                     && tx_state == TX_IDLE) begin
            tx_pending <= 1'b1;
            tx_hold    <= char8 ? wdata_in : {1'b0, wdata_in[6:0]};
        end else if (tx_state == TX_START || !tx_en) begin
            tx_pending <= 1'b0;
        end
    end
    // parity value for the outgoing byte
    always_comb begin
        unique case (par_mode)
            `PAR_ODD:  tx_par = ~^tx_shift;
            `PAR_EVEN: tx_par = ^tx_shift;
            default:   tx_par = 1'b0;
        endcase
    end
    // transmit frame sequencer
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tx_state    <= TX_IDLE;
            tx_shift    <= 8'h00;
            tx_ticks    <= 4'h0;
            tx_bits     <= 3'h0;
            tx_stop_cnt <= 1'b0;
            tx_done_out <= 1'b0;
        end else begin
            tx_done_out <= 1'b0;
            if (!tx_en) begin
                tx_state <= TX_IDLE;
            end else if (tx_state == TX_IDLE) begin
                if (tx_pending) begin
                    tx_state <= TX_START;
                    tx_shift <= tx_hold;
                    tx_ticks <= 4'h0;
                end
            end else if (tick) begin
                tx_ticks <= tx_ticks + 4'h1;
                if (tx_ticks == `TICKS_PER_BIT) begin
                    unique case (tx_state)
                        TX_START: begin
                            tx_state <= TX_DATA;
                            tx_bits  <= 3'h0;
                        end
                        TX_DATA: begin
                            tx_bits <= tx_bits + 3'h1;
                            if (tx_bits == last_bit) begin
                                tx_state    <= (par_mode == `PAR_NONE) ? TX_STOP : TX_PARITY;
                                tx_stop_cnt <= 1'b0;
                            end
                        end
                        TX_PARITY: begin
                            tx_state    <= TX_STOP;
                            tx_stop_cnt <= 1'b0;
                        end
                        TX_STOP: begin
                            tx_stop_cnt <= 1'b1;
                            if (!stop2 || tx_stop_cnt) begin
                                tx_state    <= TX_IDLE;
                                tx_done_out <= 1'b1;
                            end
                        end
                        TX_IDLE: tx_state <= TX_IDLE;
                    endcase
                end
            end
        end
    end

    // serial line drive, high outside a frame and at once on disable
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !tx_en) begin
            txd_out <= 1'b1;
        end else begin
            unique case (tx_state)
                TX_START:  txd_out <= 1'b0;
                TX_DATA:   txd_out <= tx_shift[tx_bits];
                TX_PARITY: txd_out <= tx_par;
                default:   txd_out <= 1'b1;
            endcase
        end
    end
    assign tx_busy_out = (tx_state != TX_IDLE) | tx_pending;
    // receive line synchroniser
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rxd_in;
            rx_sync <= rx_meta;
        end
    end

    // receive frame sequencer
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_state    <= RX_IDLE;
            rx_shift    <= 8'h00;
            rx_ticks    <= 4'h0;
            rx_bits     <= 3'h0;
            rx_par_bit  <= 1'b0;
            rx_complete <= 1'b0;
            rx_stop_ok  <= 1'b0;
        end else begin
            rx_complete <= 1'b0;
            if (!rx_en) begin
                rx_state <= RX_IDLE;
            end else if (rx_state == RX_IDLE) begin
                if (!rx_sync) begin
                    rx_state <= RX_START;
                    rx_ticks <= 4'h0;
                    rx_shift <= 8'h00;
                end
            end else if (tick) begin
                rx_ticks <= rx_ticks + 4'h1;
                if (rx_state == RX_START && rx_ticks == `TICKS_HALF_BIT) begin
                    rx_ticks <= 4'h0;
                    rx_bits  <= 3'h0;
                    rx_state <= rx_sync ? RX_IDLE : RX_DATA;
                end else if (rx_state != RX_START && rx_ticks == `TICKS_PER_BIT) begin
                    unique case (rx_state)
                        RX_DATA: begin
                            rx_shift[rx_bits] <= rx_sync;
                            rx_bits <= rx_bits + 3'h1;
                            if (rx_bits == last_bit) begin
                                rx_state <= (par_mode == `PAR_NONE) ? RX_STOP : RX_PARITY;
                            end
                        end
                        RX_PARITY: begin
                            rx_par_bit <= rx_sync;
                            rx_state   <= RX_STOP;
                        end
                        RX_STOP: begin
                            rx_stop_ok  <= rx_sync;
                            rx_complete <= 1'b1;
                            rx_state    <= RX_IDLE;
                        end
                        default: rx_state <= RX_IDLE;
                    endcase
                end
            end
        end
    end
    // received parity check, only for odd or even
    always_comb begin
        unique case (par_mode)
            `PAR_ODD:  rx_par_bad = ~(^rx_shift ^ rx_par_bit);
            `PAR_EVEN: rx_par_bad = ^rx_shift ^ rx_par_bit;
            default:   rx_par_bad = 1'b0;
        endcase
    end
    assign rx_data_out = char8 ? rx_shift : {1'b0, rx_shift[6:0]};
    // buffer load, flags and completion pulse together
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            receive_buffer   <= 8'h00;
            parity_err_flag  <= 1'b0;
            framing_err_flag <= 1'b0;
            overrun_err_flag <= 1'b0;
            rx_done_out      <= 1'b0;
        end else begin
            rx_done_out <= rx_complete;
            if (rx_complete) begin
                receive_buffer   <= rx_data_out;
                parity_err_flag  <= rx_par_bad;
                framing_err_flag <= ~rx_stop_ok;
                overrun_err_flag <= buf_full;
            end
        end
    end
    // unread-buffer marker; a new frame wins over a same-cycle read
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            buf_full <= 1'b0;
        end else if (rx_complete) begin
            buf_full <= 1'b1;
        end else if (buf_read) begin
            buf_full <= 1'b0;
        end
    end
endmodule

/* File: verilog/uart_cfg_params.svh */
// Purpose: offsets, field positions, codes and timing counts for the uart block
// Assumes: byte-wide memory-mapped registers
// Notes: every constant is a macro
`ifndef UART_CFG_PARAMS_SVH
`define UART_CFG_PARAMS_SVH

`define ADDR_ASYNC_CFG    16'hFF70
`define ADDR_RX_STATUS    16'hFF71
`define ADDR_SYNC_CFG     16'hFF72
`define ADDR_BAUD_SEL     16'hFF73
`define ADDR_RX_BUFFER    16'hFF74
`define ADDR_TX_DATA      16'hFF75

`define REG_RESET         8'h00

`define TX_ENABLE_BIT     7
`define RX_ENABLE_BIT     6
`define PARITY_HI_BIT     5
`define PARITY_LO_BIT     4
`define CHAR_LEN_BIT      3
`define STOP_LEN_BIT      2

`define PAR_NONE          2'h0
`define PAR_ZERO          2'h1
`define PAR_ODD           2'h2
`define PAR_EVEN          2'h3

`define SRC_EXT_CODE      4'h8
`define SRC_DIV_MAX       4'h7

`define TICKS_PER_BIT     4'hF
`define TICKS_HALF_BIT    4'h7

`endif

/* File: verilog/uart_cfg_pkg.sv */
// Purpose: types for the uart block
// Assumes: nothing
// Notes: state enums only
package uart_cfg_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
endpackage

/* File: verilog/baud_tick_gen.sv */
// Purpose: sixteen-per-bit tick from system clock divider or external pin
// Assumes: ext pin is asynchronous to clk_in
// Notes: prohibited source codes give no tick
`timescale 1ns/1ps
`include "uart_cfg_params.svh"
module baud_tick_gen
    import uart_cfg_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic [3:0] src_sel_in,
    input  wire logic       ext_clk_in,
    output logic            tick_out
);
    logic [7:0] div_cnt;
    logic       ext_meta;
    logic       ext_sync;
    logic       ext_prev;

    // mask of low n bits, n = code + 1
    function automatic logic [7:0] div_mask(input logic [3:0] code);
        div_mask = 8'hFF >> (3'h7 - code[2:0]);
    endfunction

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_clk_in;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // system clock over 2^n, or one tick per external rising edge
    always_comb begin
        if (src_sel_in <= `SRC_DIV_MAX) begin
            tick_out = ((div_cnt & div_mask(src_sel_in)) == div_mask(src_sel_in));
        end else if (src_sel_in == `SRC_EXT_CODE) begin
            tick_out = ext_sync & ~ext_prev;
        end else begin
            tick_out = 1'b0;
        end
    end
endmodule

/* File: tb/uart_remote.sv */
// Purpose: remote serial end facing the uart block
// Assumes: bit time set in clk_in cycles by the bench
// Notes: line idles high between frames
`timescale 1ns/1ps
module uart_remote (
    input  wire logic clk_in,
    input  wire logic txd_in,
    output logic      rxd_out
);
    int bit_clks = 32;
    initial rxd_out = 1'b1;
    task automatic put(input logic b);
        rxd_out <= b;
        repeat (bit_clks) @(posedge clk_in);
    endtask
    // start, data lsb first, optional parity, a single stop
    task automatic send(input logic [7:0] d, input int n, input logic hp, input logic pb,
                        input logic stp);
        @(posedge clk_in);
        put(1'b0);
        for (int i = 0; i < n; i++) put(d[i]);
        if (hp) put(pb);
        // a low stop is let go early so it cannot pose as a new start
        rxd_out <= stp;
        repeat (stp ? bit_clks : bit_clks * 3 / 4) @(posedge clk_in);
        rxd_out <= 1'b1;
    endtask
    // samples each bit at its middle
    task automatic recv(input int n, input logic hp, output logic [7:0] d, output logic pb,
                        output logic stp);
        int t;
        d = 8'h00;
        pb = 1'b0;
        t = 0;
        while (txd_in === 1'b1 && t < 4000) begin
            @(posedge clk_in);
            t++;
        end
        repeat (bit_clks / 2) @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            repeat (bit_clks) @(posedge clk_in);
            d[i] = txd_in;
        end
        if (hp) begin
            repeat (bit_clks) @(posedge clk_in);
            pb = txd_in;
        end
        repeat (bit_clks) @(posedge clk_in);
        stp = txd_in;
    endtask
endmodule

/* File: tb/uart_mode_config_properties.sv */
// Purpose: port checks on the uart config block
// Assumes: one clock, sync reset
// Notes: mirrors the async config register from bus writes
`timescale 1ns/1ps
`include "uart_cfg_params.svh"
module uart_mode_config_properties (
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic [15:0] addr_in,
    input wire logic        wr_en_in,
    input wire logic [7:0]  wdata_in,
    input wire logic        bit_wr_in,
    input wire logic [2:0]  bit_idx_in,
    input wire logic        bit_val_in,
    input wire logic        rd_en_in,
    input wire logic [7:0]  rdata_out,
    input wire logic        txd_out,
    input wire logic        tx_busy_out,
    input wire logic        tx_done_out,
    input wire logic        rx_done_out
);
    logic [7:0] cfg_m;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cfg_m <= 8'h00;
        end else if (wr_en_in && addr_in == `ADDR_ASYNC_CFG) begin
            cfg_m <= wdata_in;
        end else if (bit_wr_in && addr_in == `ADDR_ASYNC_CFG) begin
            cfg_m[bit_idx_in] <= bit_val_in;
        end
    end
    a_reset_state: assert property ($fell(sys_rst_in) |-> rdata_out == 8'h00 && txd_out
        && !tx_busy_out && !tx_done_out && !rx_done_out) else $error("state not cleared");
    a_status_zero: assert property (rd_en_in && addr_in == `ADDR_RX_STATUS
        |=> rdata_out[7:3] == 5'h00) else $error("status upper bits set");
    a_cfg_readback: assert property (rd_en_in && addr_in == `ADDR_ASYNC_CFG && !wr_en_in
        && !bit_wr_in |=> rdata_out == $past(cfg_m)) else $error("config readback wrong");
    a_idle_high: assert property (!tx_busy_out |-> txd_out)
        else $error("txd low while idle");
    a_tx_start: assert property ($rose(tx_busy_out) |-> ##[1:4] !txd_out)
        else $error("no start bit");
    a_tx_gated: assert property (!cfg_m[7] && !$past(cfg_m[7]) && !$past(cfg_m[7], 2)
        |-> txd_out && !tx_busy_out) else $error("tx active while disabled");
    a_rx_gated: assert property (!cfg_m[6] && !$past(cfg_m[6]) && !$past(cfg_m[6], 2)
        |-> !rx_done_out) else $error("rx done while disabled");
    a_stop_high: assert property (tx_done_out |-> txd_out)
        else $error("tx done outside stop");
    a_rx_pulse: assert property (rx_done_out |=> !rx_done_out)
        else $error("rx done too long");
endmodule
bind uart_mode_config uart_mode_config_properties uart_mode_config_properties_inst (
    .clk_in, .sys_rst_in, .addr_in, .wr_en_in, .wdata_in, .bit_wr_in, .bit_idx_in,
    .bit_val_in, .rd_en_in, .rdata_out, .txd_out, .tx_busy_out, .tx_done_out, .rx_done_out);

/* File: tb/uart_mode_config_test.sv */
// Purpose: register, transmit, receive and baud tests for the uart block
// Assumes: 20 MHz clock, partner model on the serial lines
// Notes: bit time is 16 ticks of the chosen source
`timescale 1ns/1ps
`include "uart_cfg_params.svh"
module uart_mode_config_test;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, wr_en_in = 1'b0, bit_wr_in = 1'b0;
    logic        bit_val_in = 1'b0, rd_en_in = 1'b0, rxd_in, txd_out, ext_baud_clk_pin_in = 1'b0;
    logic        tx_busy_out, tx_done_out, rx_done_out, got;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0]  wdata_in = 8'h00, rdata_out;
    logic [2:0]  bit_idx_in = 3'h0, ext_cnt = 3'h0;
    logic        ext_run = 1'b0;
    int          bad_count = 0, num_checks = 0, cyc = 0;
    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        ext_cnt <= ext_cnt + {2'h0, ext_run};
        ext_baud_clk_pin_in <= ext_cnt[2];
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            give_verdict();
        end
    end
    uart_mode_config uart_mode_config_inst (.clk_in, .sys_rst_in, .addr_in, .wr_en_in,
        .wdata_in, .bit_wr_in, .bit_idx_in, .bit_val_in, .rd_en_in, .rdata_out, .rxd_in,
        .ext_baud_clk_pin_in, .txd_out, .tx_busy_out, .tx_done_out, .rx_done_out);
    uart_remote uart_remote_inst (.clk_in, .txd_in(txd_out), .rxd_out(rxd_in));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask
    task automatic bwr(input logic [15:0] a, input logic [2:0] i, input logic v);
        @(posedge clk_in);
        addr_in <= a;
        bit_idx_in <= i;
        bit_val_in <= v;
        bit_wr_in <= 1'b1;
        @(posedge clk_in);
        bit_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask
    function automatic logic pbit(input logic [1:0] par, input logic [7:0] m);
        return (par == `PAR_ODD) ? ~^m : (par == `PAR_EVEN) ? ^m : 1'b0;
    endfunction
    task automatic wait_rx(output logic g);
        g = 1'b0;
        for (int t = 0; t < 14 * uart_remote_inst.bit_clks + 50 && !g; t++) begin
            @(posedge clk_in);
            g = (rx_done_out === 1'b1);
        end
    endtask
    task automatic tx_case(input logic [1:0] par, input logic cl, input logic sl,
                           input logic [7:0] d);
        logic [7:0] g, m;
        logic pb, st;
        int n, c, e, q;
        n = cl ? 8 : 7;
        m = cl ? d : {1'b0, d[6:0]};
        e = uart_remote_inst.bit_clks * (1 + 2 * sl) / 2;
        q = uart_remote_inst.bit_clks / 4;
        wr(`ADDR_ASYNC_CFG, {2'b11, par, cl, sl, 2'b00});
        fork
            uart_remote_inst.recv(n, par != `PAR_NONE, g, pb, st);
            wr(`ADDR_TX_DATA, d);
        join
        c = 0;
        while (tx_done_out !== 1'b1 && c < 400) begin
            @(posedge clk_in);
            c++;
        end
        chk(g, m);
        chk({6'h00, pb, st}, {6'h00, pbit(par, m), 1'b1});
        chk({7'h00, c >= e - q && c <= e + q}, 8'h01);
    endtask
    task automatic rx_case(input logic [7:0] d, input int n, input logic hp, input logic pb,
                           input logic stp, input logic [7:0] fl, input logic rdb);
        logic g;
        fork
            uart_remote_inst.send(d, n, hp, pb, stp);
            wait_rx(g);
        join
        chk({7'h00, g}, 8'h01);
        rd(`ADDR_RX_STATUS, fl);
        if (rdb) rd(`ADDR_RX_BUFFER, n == 8 ? d : {1'b0, d[6:0]});
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        for (int a = 0; a < 4; a++) rd(16'hFF70 + 16'(a), 8'h00);
        rd(16'hFF7F, 8'h00);
        wr(`ADDR_SYNC_CFG, 8'h00);
        wr(`ADDR_RX_STATUS, 8'hFF);
        rd(`ADDR_RX_STATUS, 8'h00);
        bwr(`ADDR_ASYNC_CFG, 3'h7, 1'b1);
        bwr(`ADDR_ASYNC_CFG, 3'h6, 1'b1);
        rd(`ADDR_ASYNC_CFG, 8'hC0);
        wr(`ADDR_BAUD_SEL, 8'h00);
        $display("test registers done");
        for (int m = 0; m < 8; m++) tx_case(2'(m), m[2], m[0], 8'hC3 ^ 8'(m * 29));
        wr(`ADDR_ASYNC_CFG, 8'h40);
        wr(`ADDR_TX_DATA, 8'hAA);
        repeat (3) @(posedge clk_in);
        chk({6'h00, tx_busy_out, txd_out}, 8'h01);
        $display("test transmit done");
        wr(`ADDR_ASYNC_CFG, 8'hCC);
        rx_case(8'h3C, 8, 0, 0, 1, 8'h00, 1);
        rx_case(8'h5A, 8, 0, 0, 0, 8'h02, 1);
        wr(`ADDR_ASYNC_CFG, 8'hFC);
        rx_case(8'h07, 8, 1, pbit(`PAR_EVEN, 8'h07), 1, 8'h00, 1);
        rx_case(8'h07, 8, 1, ~pbit(`PAR_EVEN, 8'h07), 1, 8'h04, 1);
        wr(`ADDR_ASYNC_CFG, 8'hEC);
        rx_case(8'h81, 8, 1, pbit(`PAR_ODD, 8'h81), 1, 8'h00, 1);
        rx_case(8'h81, 8, 1, ~pbit(`PAR_ODD, 8'h81), 1, 8'h04, 1);
        wr(`ADDR_ASYNC_CFG, 8'hDC);
        rx_case(8'h81, 8, 1, 1'b1, 1, 8'h00, 1);
        wr(`ADDR_ASYNC_CFG, 8'hC4);
        rx_case(8'hD5, 7, 0, 0, 1, 8'h00, 1);
        rx_case(8'h11, 7, 0, 0, 1, 8'h00, 0);
        rx_case(8'h22, 7, 0, 0, 1, 8'h01, 0);
        rx_case(8'h33, 7, 0, 0, 1, 8'h01, 1);
        rx_case(8'h44, 7, 0, 0, 1, 8'h00, 1);
        wr(`ADDR_ASYNC_CFG, 8'h84);
        fork
            uart_remote_inst.send(8'h66, 7, 0, 0, 1);
            wait_rx(got);
        join
        chk({7'h00, got}, 8'h00);
        $display("test receive done");
        wr(`ADDR_BAUD_SEL, 8'h10);
        uart_remote_inst.bit_clks = 64;
        tx_case(`PAR_EVEN, 1, 0, 8'h96);
        rx_case(8'h96, 8, 1, pbit(`PAR_EVEN, 8'h96), 1, 8'h00, 1);
        wr(`ADDR_BAUD_SEL, 8'h80);
        ext_run <= 1'b1;
        uart_remote_inst.bit_clks = 128;
        tx_case(`PAR_ODD, 1, 1, 8'h5E);
        rx_case(8'h5E, 8, 1, pbit(`PAR_ODD, 8'h5E), 1, 8'h00, 1);
        $display("test baud done");
        give_verdict();
    end
endmodule
